/* File: logic/ias_consts.vh */
/*
 Constants for the interrupt acknowledge sequencer: encodings, vector numbers,
 status field positions and the acknowledge timeout.
 Assumes inclusion by bare name from the logic/ files.
*/
`ifndef IAS_CONSTS_VH
`define IAS_CONSTS_VH

`define IAS_FC_CPU_SPACE      3'h7
`define IAS_ADDR_HI_ONES      20'hFFFFF
`define IAS_ADDR_BIT0         1'h1
`define IAS_SPURIOUS_VEC      8'h18
`define IAS_AUTOVEC_BASE      8'h18
`define IAS_LEVEL_SEVEN       3'h7
`define IAS_ARB_NONE          4'h0
`define IAS_SR_S_BIT          13
`define IAS_SR_T_HI_BIT       15
`define IAS_SR_T_LO_BIT       14
`define IAS_SR_MASK_LSB       8
`define IAS_SR_RESET          16'h2700
`define IAS_STACK_WORDS       3'h3
`define IAS_ACK_TIMEOUT_NS    64
`define IAS_CLK_PERIOD_NS     4
`define IAS_ACK_TIMEOUT_CYC   (`IAS_ACK_TIMEOUT_NS / `IAS_CLK_PERIOD_NS)

`endif

/* File: logic/ias_req_filter.v */
/*
 Request qualifier: picks the highest pending level above the mask, level
 seven always allowed on a fresh falling edge.
 Assumes the request pins are synchronous to core_clk_i.
*/
`timescale 1ns/1ns
`include "ias_consts.vh"

module ias_req_filter
(
   input  wire       core_clk_i,
   input  wire       rst_b_i,
   input  wire [7:1] request_n_i,
   input  wire [2:0] mask_i,
   input  wire       nmi_taken_i,
   output reg  [2:0] pend_level_o,
   output wire       pend_valid_o
);

   reg  [7:1] prev_n;
   reg        nmi_armed;
   reg  [2:0] prev_mask;
   reg  [2:0] next_level;
   integer    idx;

   // Highest valid level wins; a level one to six at or below the mask is not seen
   always @*
   begin
      next_level = 3'h0;
      for (idx = 1; idx < 7; idx = idx + 1)
         if (!request_n_i[idx] && !prev_n[idx] && idx[2:0] > mask_i)
            next_level = idx[2:0];
      if (nmi_armed)
         next_level = `IAS_LEVEL_SEVEN;
   end

   // Two samples required; level seven armed by an edge or a mask drop
   always @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         prev_n       <= 7'h7F;
         nmi_armed    <= 1'b0;
         prev_mask    <= 3'h7;
         pend_level_o <= 3'h0;
      end
      else
      begin
         prev_n       <= request_n_i;
         prev_mask    <= mask_i;
         pend_level_o <= next_level;
         if (!request_n_i[7] && !prev_n[7] &&
             (nmi_edge_seen(prev_n[7], request_n_i[7]) || (prev_mask == 3'h7 && mask_i != 3'h7)))
            nmi_armed <= 1'b1;
         else if (nmi_taken_i)
            nmi_armed <= 1'b0;
      end
   end

   // Edge seen one sample earlier: prev high went low last cycle
   reg nmi_fall;
   always @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         nmi_fall <= 1'b0;
      else
         nmi_fall <= prev_n[7] & ~request_n_i[7];
   end

   function nmi_edge_seen;
      input p;
      input c;
      begin
         nmi_edge_seen = nmi_fall & ~p & ~c;
      end
   endfunction

   assign pend_valid_o = (pend_level_o != 3'h0);

endmodule // ias_req_filter

/* File: logic/ias_ack_timer.v */
/*
 Bus monitor for the acknowledge cycle: counts while the cycle runs and
 flags a timeout.
 Assumes run drops between cycles to clear it and stays high through the cycle.
*/
`timescale 1ns/1ns
`include "ias_consts.vh"

module ias_ack_timer
(
   input  wire core_clk_i,
   input  wire rst_b_i,
   input  wire run_i,
   output wire expired_o
);

   reg [7:0] count;

   // Saturating count, cleared whenever no cycle is running
   always @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         count <= 8'h00;
      else if (!run_i)
         count <= 8'h00;
      else if (!expired_o)
         count <= count + 8'h01;
   end

   assign expired_o = (count >= `IAS_ACK_TIMEOUT_CYC);

endmodule // ias_ack_timer

/* File: logic/ias_sequencer.v */
/*
 Interrupt acknowledge sequencer: stacks state, enters supervisor mode,
 runs the acknowledge cycle, obtains a vector and loads the handler address.
 Assumes responders keep the acknowledge signals steady until the cycle ends,
 and that the core pulses boundary_i at instruction boundaries.
*/
`timescale 1ns/1ns
`include "ias_consts.vh"

// Summary of operation
// - Start only at boundary or after exceptions
// - Stack state, set supervisor, clear trace
// - Function code all ones during acknowledge
// - Address ones, level in bits 3..1
// - Copy acknowledged level into mask
// - No contender gives bus error, spurious vector
// - Winner supplies vector with size acknowledge
// - Autovector request gives level-based vector
// - Timeout gives bus error, spurious vector
// - Vector to table address, load counter
// - Ignore at-or-below mask; level seven always
module ias_sequencer
(
   input  wire        core_clk_i,
   input  wire        rst_b_i,
   input  wire        boundary_i,
   input  wire        exc_busy_i,
   input  wire [7:1]  request_n_i,
   input  wire [15:0] sr_load_i,
   input  wire        sr_load_en_i,
   input  wire [31:0] vector_base_i,
   input  wire [31:0] stack_ptr_i,
   input  wire [31:0] cur_pc_i,
   input  wire [3:0]  arbitration_priority_field_i,
   input  wire [7:0]  data_i,
   input  wire [1:0]  data_size_ack_n_i,
   input  wire        autovector_request_n_i,
   input  wire [31:0] mem_rdata_i,
   input  wire        mem_ready_i,
   output reg  [2:0]  function_code_out_o,
   output reg  [23:0] ack_addr_o,
   output reg         ack_strobe_o,
   output reg         bus_error_n_o,
   output reg         mem_req_o,
   output reg         mem_write_o,
   output reg  [31:0] mem_addr_o,
   output reg  [31:0] mem_wdata_o,
   output reg  [15:0] status_o,
   output reg  [31:0] program_counter_o,
   output reg  [7:0]  vector_o,
   output reg         handler_go_o,
   output wire        busy_o
);

   localparam ST_IDLE  = 3'h0;
   localparam ST_STACK = 3'h1;
   localparam ST_ACK   = 3'h2;
   localparam ST_BUS_ERROR_N  = 3'h3;
   localparam ST_FETCH = 3'h4;
   localparam ST_DONE  = 3'h5;

   reg  [2:0]  state;
   reg  [2:0]  next_state;
   reg  [2:0]  level;
   reg  [2:0]  stack_idx;
   reg  [15:0] saved_sr;
   reg  [31:0] sp;
   wire [2:0]  pend_level;
   wire        pend_valid;
   wire        timed_out;
   wire        nmi_taken;

   // Table entry address: base plus four times the vector number
   function [31:0] vec_addr;
      input [31:0] base;
      input [7:0]  vec;
      begin
         vec_addr = base + {22'h000000, vec, 2'h0};
      end
   endfunction

   assign nmi_taken = (state == ST_STACK) && (level == `IAS_LEVEL_SEVEN);
   assign busy_o    = (state != ST_IDLE);

   ias_req_filter u_filter
   (
      .core_clk_i   (core_clk_i),
      .rst_b_i      (rst_b_i),
      .request_n_i  (request_n_i),
      .mask_i       (status_o[`IAS_SR_MASK_LSB+2:`IAS_SR_MASK_LSB]),
      .nmi_taken_i  (nmi_taken),
      .pend_level_o (pend_level),
      .pend_valid_o (pend_valid)
   );

   ias_ack_timer u_timer
   (
      .core_clk_i (core_clk_i),
      .rst_b_i    (rst_b_i),
      .run_i      (state == ST_ACK),
      .expired_o  (timed_out)
   );

   // Next-state selection
   always @*
   begin
      next_state = state;
      case (state)
         ST_IDLE:
            if (pend_valid && (boundary_i || !exc_busy_i) && !sr_load_en_i)
               next_state = ST_STACK;
         ST_STACK:
            if (mem_ready_i && stack_idx == `IAS_STACK_WORDS - 3'h1)
               next_state = ST_ACK;
         ST_ACK:
            if (arbitration_priority_field_i == `IAS_ARB_NONE)
               next_state = ST_BUS_ERROR_N;
            else if (data_size_ack_n_i != 2'h3 || !autovector_request_n_i)
               next_state = ST_FETCH;
            else if (timed_out)
               next_state = ST_BUS_ERROR_N;
         ST_BUS_ERROR_N:
            next_state = ST_FETCH;
         ST_FETCH:
            if (mem_ready_i)
               next_state = ST_DONE;
         ST_DONE:
            next_state = ST_IDLE;
         default:
            next_state = ST_IDLE;
      endcase
   end

   // Sequencer registers; the stack writes SR, then the whole 32-bit PC word twice
   always @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state               <= ST_IDLE;
         level               <= 3'h0;
         stack_idx           <= 3'h0;
         saved_sr            <= 16'h0000;
         sp                  <= 32'h00000000;
         status_o            <= `IAS_SR_RESET;
         program_counter_o   <= 32'h00000000;
         vector_o            <= 8'h00;
         function_code_out_o <= 3'h0;
         ack_addr_o          <= 24'h000000;
         ack_strobe_o        <= 1'b0;
         bus_error_n_o       <= 1'b1;
         mem_req_o           <= 1'b0;
         mem_write_o         <= 1'b0;
         mem_addr_o          <= 32'h00000000;
         mem_wdata_o         <= 32'h00000000;
         handler_go_o        <= 1'b0;
      end
      else
      begin
         state        <= next_state;
         handler_go_o <= 1'b0;
         bus_error_n_o <= 1'b1;
         case (state)
            ST_IDLE:
            begin
               if (sr_load_en_i)
                  status_o <= sr_load_i;
               if (next_state == ST_STACK)
               begin
                  // Level frozen here; later higher requests wait a new round
                  level     <= pend_level;
                  saved_sr  <= status_o;
                  sp        <= stack_ptr_i - 32'h00000004;
                  stack_idx <= 3'h0;
                  status_o[`IAS_SR_S_BIT]    <= 1'b1;
                  status_o[`IAS_SR_T_HI_BIT] <= 1'b0;
                  status_o[`IAS_SR_T_LO_BIT] <= 1'b0;
                  mem_req_o   <= 1'b1;
                  mem_write_o <= 1'b1;
                  mem_addr_o  <= stack_ptr_i - 32'h00000004;
                  mem_wdata_o <= {16'h0000, status_o};
               end
            end
            ST_STACK:
               if (mem_ready_i)
               begin
                  stack_idx <= stack_idx + 3'h1;
                  sp        <= sp - 32'h00000004;
                  mem_addr_o <= sp - 32'h00000004;
                  mem_wdata_o <= cur_pc_i;
                  if (next_state == ST_ACK)
                  begin
                     mem_req_o           <= 1'b0;
                     mem_write_o         <= 1'b0;
                     ack_strobe_o        <= 1'b1;
                     function_code_out_o <= `IAS_FC_CPU_SPACE;
                     ack_addr_o <= {`IAS_ADDR_HI_ONES, level, `IAS_ADDR_BIT0};
                     status_o[`IAS_SR_MASK_LSB+2:`IAS_SR_MASK_LSB] <= level;
                  end
               end
            ST_ACK:
               if (next_state != ST_ACK)
               begin
                  ack_strobe_o        <= 1'b0;
                  function_code_out_o <= 3'h0;
                  if (next_state == ST_BUS_ERROR_N)
                     bus_error_n_o <= 1'b0;
                  else if (!autovector_request_n_i)
                     vector_o <= `IAS_AUTOVEC_BASE + {5'h00, level};
                  else
                     vector_o <= data_i;
                  if (next_state == ST_FETCH)
                  begin
                     mem_req_o  <= 1'b1;
                     mem_addr_o <= vec_addr(vector_base_i, !autovector_request_n_i ?
                                   `IAS_AUTOVEC_BASE + {5'h00, level} : data_i);
                  end
               end
            ST_BUS_ERROR_N:
            begin
               vector_o   <= `IAS_SPURIOUS_VEC;
               mem_req_o  <= 1'b1;
               mem_addr_o <= vec_addr(vector_base_i, `IAS_SPURIOUS_VEC);
            end
            ST_FETCH:
               if (mem_ready_i)
               begin
                  mem_req_o         <= 1'b0;
                  program_counter_o <= mem_rdata_i;
               end
            ST_DONE:
               handler_go_o <= 1'b1;
            default:
               mem_req_o <= 1'b0;
         endcase
      end
   end

endmodule // ias_sequencer

/* File: bench/ias_seq_chk.sv */
/* Port checker for the acknowledge sequencer.
 Assumes a bind onto ias_sequencer; one clock, async low reset. */
`timescale 1ns/1ns
module ias_seq_chk
(
   input wire        core_clk_i,
   input wire        rst_b_i,
   input wire [3:0]  arbitration_priority_field_i,
   input wire [31:0] vector_base_i,
   input wire [31:0] mem_rdata_i,
   input wire        mem_ready_i,
   input wire [2:0]  function_code_out_o,
   input wire [23:0] ack_addr_o,
   input wire        ack_strobe_o,
   input wire        bus_error_n_o,
   input wire        mem_req_o,
   input wire        mem_write_o,
   input wire [31:0] mem_addr_o,
   input wire [31:0] mem_wdata_o,
   input wire [15:0] status_o,
   input wire [31:0] program_counter_o,
   input wire [7:0]  vector_o,
   input wire        handler_go_o,
   input wire        busy_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   reg [5:0]  ack_len;
   reg [31:0] tbl_word;
   // Ack length and last table word; a counter, since a long repeat would stall the tools
   always @(posedge core_clk_i or negedge rst_b_i)
      if (!rst_b_i)
      begin
         ack_len  <= 6'h00;
         tbl_word <= 32'h00000000;
      end
      else
      begin
         ack_len <= ack_strobe_o ? ack_len + 6'h01 : 6'h00;
         if (mem_req_o && !mem_write_o && mem_ready_i)
            tbl_word <= mem_rdata_i;
      end
   sequence s_start; $rose(busy_o); endsequence
   sequence s_stack; mem_req_o && mem_write_o; endsequence
   property p_stack; s_start |-> ##[0:2] s_stack; endproperty
   a_stack: assert property (p_stack) else $error("no stack write");
   // First stacked word must be the status as it stood before supervisor entry
   property p_sr_word; s_start |-> mem_wdata_o == {16'h0000, $past(status_o)}; endproperty
   a_sr_word: assert property (p_sr_word) else $error("bad stacked status");
   property p_super; ack_strobe_o |-> status_o[15:13] == 3'h1; endproperty
   a_super: assert property (p_super) else $error("not supervisor");
   property p_fc; ack_strobe_o |-> function_code_out_o == 3'h7; endproperty
   a_fc: assert property (p_fc) else $error("bad function code");
   property p_addr; ack_strobe_o |-> ack_addr_o[23:4] == 20'hFFFFF && ack_addr_o[0]; endproperty
   a_addr: assert property (p_addr) else $error("bad ack address");
   property p_mask; ack_strobe_o ##1 ack_strobe_o |-> status_o[10:8] == ack_addr_o[3:1]; endproperty
   a_mask: assert property (p_mask) else $error("mask not level");
   property p_spur; ack_strobe_o && arbitration_priority_field_i == 4'h0 |-> ##[0:2] !bus_error_n_o; endproperty
   a_spur: assert property (p_spur) else $error("no bus error");
   property p_tmo; ack_len <= 6'h12; endproperty
   a_tmo: assert property (p_tmo) else $error("ack too long");
   property p_table; mem_req_o && !mem_write_o |-> mem_addr_o == vector_base_i + {22'h0, vector_o, 2'h0}; endproperty
   a_table: assert property (p_table) else $error("bad table address");
   property p_pc; handler_go_o |-> program_counter_o == tbl_word; endproperty
   a_pc: assert property (p_pc) else $error("bad handler address");
endmodule // ias_seq_chk

/* File: bench/ias_resp_model.sv */
/* Far side: one interrupt source plus stack and vector memory.
 Assumes the sequencer holds strobe and request until answered. */
`timescale 1ns/1ns
module ias_resp_model
(
   input  wire        core_clk_i,
   input  wire        rst_b_i,
   input  wire [1:0]  mode_i,
   input  wire [2:0]  own_level_i,
   input  wire        slow_i,
   input  wire        ack_strobe_i,
   input  wire [23:0] ack_addr_i,
   input  wire        mem_req_i,
   input  wire [31:0] mem_addr_i,
   output reg  [3:0]  arb_o,
   output reg  [7:0]  vec_o,
   output reg  [1:0]  data_size_ack_n_n_o,
   output reg         autovector_request_n_n_o,
   output reg  [31:0] rdata_o,
   output reg         ready_o
);
   // Modes: 0 vector, 1 autovector, 2 no contender, 3 never answers
   reg  [2:0] dly;
   wire       hit  = ack_strobe_i && ack_addr_i[3:1] == own_level_i;
   wire       late = dly >= (slow_i ? 3'h3 : 3'h0);
   // Falling-edge drive; idle data lines toggle so stale values never look valid
   always @(negedge core_clk_i or negedge rst_b_i)
      if (!rst_b_i)
      begin
         dly       <= 3'h0;
         arb_o     <= 4'h0;
         vec_o     <= 8'h00;
         data_size_ack_n_n_o <= 2'h3;
         autovector_request_n_n_o  <= 1'h1;
         rdata_o   <= 32'h00000000;
         ready_o   <= 1'h0;
      end
      else
      begin
         dly       <= (ready_o || !(hit || mem_req_i)) ? 3'h0 : (late ? dly : dly + 3'h1);
         arb_o     <= (hit && mode_i != 2'h2) ? 4'hC : 4'h0;
         vec_o     <= (hit && mode_i == 2'h0) ? {5'h08, own_level_i} : ~vec_o;
         data_size_ack_n_n_o <= (hit && late && mode_i == 2'h0) ? 2'h0 : 2'h3;
         autovector_request_n_n_o  <= !(hit && late && mode_i == 2'h1);
         ready_o   <= mem_req_i && !ready_o && late;
         rdata_o   <= (mem_req_i && !ready_o && late) ? ~mem_addr_i : ~rdata_o;
      end
endmodule // ias_resp_model

/* File: bench/tb_ias_sequencer.sv */
/* Bench for the acknowledge sequencer with the far-side model.
 Assumes logic/ files, model and checker compiled first. */
`timescale 1ns/1ns
module tb_ias_sequencer;
   localparam [31:0] BASE = 32'h00004000;
   reg         core_clk_i, rst_b_i = 1'b0, boundary_i = 1'b1, exc_busy_i = 1'b0, sr_load_en_i = 1'b0, slow = 1'b0;
   reg  [7:1]  request_n_i = 7'h7F;
   reg  [15:0] sr_load_i = 16'h0000;
   reg  [1:0]  mode = 2'h0;
   reg  [2:0]  lvl = 3'h1;
   reg         bus_error_n_seen = 1'b0;
   wire [31:0] vector_base_i = BASE, stack_ptr_i = 32'h00008000, cur_pc_i = 32'h00001234;
   wire [31:0] mem_rdata_i, mem_addr_o, mem_wdata_o, program_counter_o;
   wire [3:0]  arbitration_priority_field_i;
   wire [7:0]  data_i, vector_o;
   wire [1:0]  data_size_ack_n_i;
   wire [23:0] ack_addr_o;
   wire [15:0] status_o;
   wire [2:0]  function_code_out_o;
   wire        autovector_request_n_i, mem_ready_i, ack_strobe_o, bus_error_n_o, mem_req_o, mem_write_o;
   wire        handler_go_o, busy_o;
   integer     num_errors = 0, samples_checked = 0, cyc = 0;
   ias_sequencer u_dut (.core_clk_i, .rst_b_i, .boundary_i, .exc_busy_i, .request_n_i, .sr_load_i, .sr_load_en_i,
      .vector_base_i, .stack_ptr_i, .cur_pc_i, .arbitration_priority_field_i, .data_i, .data_size_ack_n_i,
      .autovector_request_n_i, .mem_rdata_i, .mem_ready_i, .function_code_out_o, .ack_addr_o, .ack_strobe_o,
      .bus_error_n_o, .mem_req_o, .mem_write_o, .mem_addr_o, .mem_wdata_o, .status_o, .program_counter_o,
      .vector_o, .handler_go_o, .busy_o);
   ias_resp_model u_resp (.core_clk_i, .rst_b_i, .mode_i(mode), .own_level_i(lvl), .slow_i(slow),
      .ack_strobe_i(ack_strobe_o), .ack_addr_i(ack_addr_o), .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o),
      .arb_o(arbitration_priority_field_i), .vec_o(data_i), .data_size_ack_n_n_o(data_size_ack_n_i),
      .autovector_request_n_n_o(autovector_request_n_i), .rdata_o(mem_rdata_i), .ready_o(mem_ready_i));
   // 4 ns clock
   initial
   begin
      core_clk_i = 1'b0;
      forever #2 core_clk_i = ~core_clk_i;
   end
   // Hang guard and bus error watch; sampled mid-cycle so the one-cycle pulse is settled
   always @(negedge core_clk_i)
   begin
      cyc = cyc + 1;
      if (!bus_error_n_o)
         bus_error_n_seen = 1'b1;
      if (cyc == 20000)
      begin
         num_errors = num_errors + 1;
         print_verdict;
      end
   end
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp)
         begin
            num_errors = num_errors + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", samples_checked, num_errors);
         if (num_errors == 0 && samples_checked > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // Status may only be loaded while idle
   task set_mask(input [2:0] m);
      begin
         @(negedge core_clk_i);
         sr_load_i = {5'h04, m, 8'h00};
         sr_load_en_i = 1'b1;
         @(negedge core_clk_i);
         sr_load_en_i = 1'b0;
      end
   endtask
   // Full service of level l above mask m, far side answering in mode md
   task service(input [2:0] m, input [2:0] l, input [1:0] md, input [7:0] ev, input eb);
      integer n;
      begin
         set_mask(m);
         lvl = l;
         mode = md;
         bus_error_n_seen = 1'b0;
         request_n_i[l] = 1'b0;
         for (n = 0; n < 300 && handler_go_o !== 1'b1; n = n + 1)
            @(posedge core_clk_i) #1;
         check("vector", {24'h0, vector_o}, {24'h0, ev});
         check("handler pc", program_counter_o, ~(BASE + {22'h0, ev, 2'h0}));
         check("mask", {29'h0, status_o[10:8]}, {29'h0, l});
         check("s and trace", {29'h0, status_o[15:13]}, 32'h00000001);
         check("bus error", {31'h0, bus_error_n_seen}, {31'h0, eb});
         @(negedge core_clk_i);
         request_n_i[l] = 1'b1;
         repeat (2) @(negedge core_clk_i);
         check("idle after", {31'h0, busy_o}, 32'h00000000);
         $display("test done: level %0d mode %0d", l, md);
      end
   endtask
   // Level equal to mask is ignored; level seven passes a full mask
   task t_refuse;
      begin
         set_mask(3'h5);
         request_n_i[5] = 1'b0;
         repeat (20) @(negedge core_clk_i);
         check("masked idle", {31'h0, busy_o}, 32'h00000000);
         request_n_i[5] = 1'b1;
         service(3'h7, 3'h7, 2'h0, 8'h47, 1'b0);
      end
   endtask
   // No start while a higher exception runs off a boundary
   task t_gate;
      begin
         exc_busy_i = 1'b1;
         boundary_i = 1'b0;
         set_mask(3'h0);
         request_n_i[6] = 1'b0;
         repeat (20) @(negedge core_clk_i);
         check("held off", {31'h0, busy_o}, 32'h00000000);
         boundary_i = 1'b1;
         service(3'h0, 3'h6, 2'h0, 8'h46, 1'b0);
         exc_busy_i = 1'b0;
      end
   endtask
   initial
   begin
      repeat (6) @(negedge core_clk_i);
      rst_b_i = 1'b1;
      check("reset status", {16'h0, status_o}, 32'h00002700);
      service(3'h0, 3'h3, 2'h0, 8'h43, 1'b0);
      service(3'h0, 3'h1, 2'h1, 8'h19, 1'b0);
      slow = 1'b1;
      service(3'h2, 3'h5, 2'h1, 8'h1D, 1'b0);
      service(3'h0, 3'h2, 2'h2, 8'h18, 1'b1);
      service(3'h1, 3'h4, 2'h3, 8'h18, 1'b1);
      slow = 1'b0;
      t_refuse;
      t_gate;
      print_verdict;
   end
endmodule // tb_ias_sequencer
bind ias_sequencer ias_seq_chk u_chk (.core_clk_i, .rst_b_i, .arbitration_priority_field_i, .vector_base_i,
   .mem_rdata_i, .mem_ready_i, .function_code_out_o, .ack_addr_o, .ack_strobe_o, .bus_error_n_o, .mem_req_o,
   .mem_write_o, .mem_addr_o, .mem_wdata_o, .status_o, .program_counter_o, .vector_o, .handler_go_o, .busy_o);
